// >>> hbp_consts.svh
// Purpose: Shared constants for the host bus byte-lane port
// Assumes: Both ends run on one 100 MHz clock
// Notes:   Timing counts are in clk_in cycles, the clock period HBP_CLK_NS in ns
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

// ----------------------------------------
// Lane and decode values
// ----------------------------------------
`define HBP_LANES 4
`define HBP_LANES_NONE 4'h0
`define HBP_BE_IDLE 4'hF
`define HBP_BE_UPPER_ONLY 2'h3
`define HBP_DECODE_LSB 4

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define HBP_CLK_NS 10
`define HBP_LOCAL_BUS_CLOCK_HALF 4
`define HBP_HOST_SETTLE 8

`endif

// >>> hbp_pkg.sv
// Purpose: Types for the host bus byte-lane port
// Assumes: Nothing beyond the constants header
// Notes:   State types for both ends
package hbp_pkg;
    typedef enum logic [2:0] {
        HBP_D_IDLE, HBP_D_RD_WAIT, HBP_D_HOLD, HBP_D_WR_HOLD, HBP_D_WR_WAIT
    } hbp_dev_state_type;
    typedef enum logic [2:0] {
        HBP_H_IDLE, HBP_H_SETUP, HBP_H_STROBE, HBP_H_WAIT, HBP_H_RELEASE
    } hbp_host_state_type;
endpackage

// >>> hbp_bus_if.sv
// Purpose: Pin-level carrier between host and device ends
// Assumes: Data lanes resolved here, device drive wins
// Notes:   No high-impedance value; enables pick the driver
`timescale 1ns/1ns
interface hbp_bus_if;
    logic [31:0] host_data;
    logic [3:0] host_data_oe_n;
    logic [31:0] dev_data;
    logic [3:0] dev_data_oe_n;
    logic [31:0] bus_data;
    logic [15:1] addr;
    logic byte_enable_lane0_n;
    logic byte_enable_lane1_n;
    logic byte_enable_lane2_n;
    logic byte_enable_lane3_n;
    logic io_space_qualifier;
    logic read_strobe_n;
    logic write_strobe_n;
    logic sync_address_strobe_n;
    logic sync_cycle_strobe_n;
    logic access_direction;
    logic ready_return_n;
    logic local_bus_clock;
    logic bus_type_strap_n;
    logic async_ready;
    logic local_device_select_n;

    // Lane resolution, idle lanes read as zero
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!dev_data_oe_n[i]) begin
                bus_data[i*8 +: 8] = dev_data[i*8 +: 8];
            end else if (!host_data_oe_n[i]) begin
                bus_data[i*8 +: 8] = host_data[i*8 +: 8];
            end else begin
                bus_data[i*8 +: 8] = 8'h00;
            end
        end
    end

    modport device (
        input bus_data, addr, byte_enable_lane0_n, byte_enable_lane1_n,
        byte_enable_lane2_n, byte_enable_lane3_n, io_space_qualifier,
        read_strobe_n, write_strobe_n, sync_address_strobe_n, sync_cycle_strobe_n,
        access_direction, ready_return_n, local_bus_clock, bus_type_strap_n,
        output dev_data, dev_data_oe_n, async_ready, local_device_select_n
    );
    modport host (
        input bus_data, async_ready, local_device_select_n,
        output host_data, host_data_oe_n, addr, byte_enable_lane0_n,
        byte_enable_lane1_n, byte_enable_lane2_n, byte_enable_lane3_n,
        io_space_qualifier, read_strobe_n, write_strobe_n, sync_address_strobe_n,
        sync_cycle_strobe_n, access_direction, ready_return_n, local_bus_clock,
        bus_type_strap_n
    );
endinterface

// >>> hbp_device.sv
// Purpose: Device end of the host bus byte-lane port
// Assumes: All pins synchronised to clk_in by two flops
// Notes:   Ready lags the strobe by the synchroniser delay, plus up to one local clock in sync mode
`timescale 1ns/1ns
`include "hbp_consts.svh"
module hbp_device #(
    parameter int DECODE_BITS = 12
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pins
    hbp_bus_if.device bus,
    // Decode base
    input wire logic [15:4] base_addr_in,
    // Register request
    output logic req_valid_out,
    output logic req_write_out,
    output logic [15:1] req_addr_out,
    output logic [3:0] req_lanes_out,
    output logic [31:0] req_wdata_out,
    // Register answer
    input wire logic rsp_valid_in,
    input wire logic [31:0] rsp_rdata_in,
    // Status
    output logic sync_mode_out
);
    import hbp_pkg::*;

    if (DECODE_BITS != 12) begin : g_bad_decode
        $error("Decode must cover address bits 15 to 4");
    end

    // Lane selection from enables
    function automatic logic [3:0] lane_sel(input logic [3:0] be_n, input logic sync_mode);
        if (sync_mode) begin
            lane_sel = ~be_n;
        end else begin
            lane_sel = {2'h0, ~be_n[1:0]};
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int SW = 32 + 15 + 4 + 9;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] meta_reg;
    logic [SW-1:0] pin_reg;
    logic local_bus_clock_prev_reg;
    assign pin_raw = {bus.bus_data, bus.addr, bus.byte_enable_lane3_n,
        bus.byte_enable_lane2_n, bus.byte_enable_lane1_n, bus.byte_enable_lane0_n,
        bus.io_space_qualifier, bus.read_strobe_n, bus.write_strobe_n,
        bus.sync_address_strobe_n, bus.sync_cycle_strobe_n, bus.access_direction,
        bus.ready_return_n, bus.local_bus_clock, bus.bus_type_strap_n};
    always_ff @(posedge clk_in) begin
        meta_reg <= pin_raw;
        pin_reg <= meta_reg;
        local_bus_clock_prev_reg <= pin_reg[1];
    end

    logic [31:0] s_data;
    logic [15:1] s_addr;
    logic [3:0] s_be_n;
    logic s_aen, s_rd_n, s_wr_n, s_cyc_n, s_dir, s_local_bus_clock, s_strap_n;
    assign s_data = pin_reg[59:28];
    assign s_addr = pin_reg[27:13];
    assign s_be_n = pin_reg[12:9];
    assign s_aen = pin_reg[8];
    assign s_rd_n = pin_reg[7];
    assign s_wr_n = pin_reg[6];
    assign s_cyc_n = pin_reg[4];
    assign s_dir = pin_reg[3];
    assign s_local_bus_clock = pin_reg[1];
    assign s_strap_n = pin_reg[0];

    // ----------------------------------------
    // Mode strap, caught after reset release
    // ----------------------------------------
    logic mode_done_reg, mode_done_next;
    logic sync_mode_reg, sync_mode_next;
    always_comb begin
        mode_done_next = 1'b1;
        sync_mode_next = sync_mode_reg;
        if (!mode_done_reg) begin
            sync_mode_next = !s_strap_n;
        end
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic hit;
    logic [3:0] lanes;
    logic addr1;
    logic strobe_low;
    logic local_bus_clock_rise;
    always_comb begin
        hit = (s_addr[15:4] == base_addr_in) && !s_aen;
        lanes = lane_sel(s_be_n, sync_mode_reg);
        // Local bus holds A1 low, so upper enables give it
        addr1 = sync_mode_reg ? (s_be_n[1:0] == `HBP_BE_UPPER_ONLY) : s_addr[1];
        strobe_low = sync_mode_reg ? !s_cyc_n : (!s_rd_n || !s_wr_n);
        local_bus_clock_rise = s_local_bus_clock && !local_bus_clock_prev_reg;
    end

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    hbp_dev_state_type state_reg, state_next;
    logic ready_reg, ready_next;
    logic rd_reg, rd_next;
    logic ldev_n_reg, ldev_n_next;
    logic [3:0] lanes_reg, lanes_next;
    logic [15:1] addr_reg, addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [31:0] rdata_reg, rdata_next;
    logic req_reg, req_next;

    always_comb begin
        state_next = state_reg;
        ready_next = ready_reg;
        rd_next = rd_reg;
        lanes_next = lanes_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        req_next = 1'b0;
        ldev_n_next = !hit;
        unique case (state_reg)
            HBP_D_IDLE: begin
                if (!mode_done_reg) begin
                    state_next = HBP_D_IDLE;
                end else if (sync_mode_reg) begin
                    if (local_bus_clock_rise && !s_cyc_n && hit) begin
                        rd_next = !s_dir;
                        lanes_next = lanes;
                        addr_next = {s_addr[15:2], addr1};
                        wdata_next = s_data;
                        req_next = 1'b1;
                        ready_next = 1'b0;
                        state_next = s_dir ? HBP_D_WR_WAIT : HBP_D_RD_WAIT;
                    end
                end else if (!s_rd_n && hit) begin
                    rd_next = 1'b1;
                    lanes_next = lanes;
                    addr_next = s_addr;
                    req_next = 1'b1;
                    ready_next = 1'b0;
                    state_next = HBP_D_RD_WAIT;
                end else if (!s_wr_n && hit) begin
                    rd_next = 1'b0;
                    lanes_next = lanes;
                    addr_next = s_addr;
                    state_next = HBP_D_WR_HOLD;
                end
            end
            HBP_D_RD_WAIT: begin
                if (rsp_valid_in) begin
                    rdata_next = rsp_rdata_in;
                    ready_next = 1'b1;
                    state_next = HBP_D_HOLD;
                end
            end
            HBP_D_HOLD: begin
                if (!strobe_low) begin
                    state_next = HBP_D_IDLE;
                end
            end
            HBP_D_WR_HOLD: begin
                // Posted write, data taken as the strobe ends
                if (s_wr_n) begin
                    wdata_next = s_data;
                    req_next = 1'b1;
                    state_next = HBP_D_WR_WAIT;
                end
            end
            HBP_D_WR_WAIT: begin
                if (rsp_valid_in) begin
                    ready_next = 1'b1;
                    state_next = sync_mode_reg ? HBP_D_HOLD : HBP_D_IDLE;
                end else if (!sync_mode_reg) begin
                    // A new strobe while busy must wait
                    ready_next = !strobe_low;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mode_done_reg <= 1'b0;
            sync_mode_reg <= 1'b0;
            state_reg <= HBP_D_IDLE;
            ready_reg <= 1'b1;
            rd_reg <= 1'b0;
            ldev_n_reg <= 1'b1;
            lanes_reg <= `HBP_LANES_NONE;
            addr_reg <= 15'h0000;
            wdata_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            req_reg <= 1'b0;
        end else begin
            mode_done_reg <= mode_done_next;
            sync_mode_reg <= sync_mode_next;
            state_reg <= state_next;
            ready_reg <= ready_next;
            rd_reg <= rd_next;
            ldev_n_reg <= ldev_n_next;
            lanes_reg <= lanes_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            req_reg <= req_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [3:0] drive;
    assign drive = (state_reg == HBP_D_HOLD && rd_reg) ? lanes_reg : `HBP_LANES_NONE;
    assign bus.dev_data = rdata_reg;
    assign bus.dev_data_oe_n = ~drive;
    assign bus.async_ready = ready_reg;
    assign bus.local_device_select_n = ldev_n_reg;
    assign req_valid_out = req_reg;
    assign req_write_out = !rd_reg;
    assign req_addr_out = addr_reg;
    assign req_lanes_out = lanes_reg;
    // Unselected lanes are masked off
    assign req_wdata_out = wdata_reg & {{8{lanes_reg[3]}}, {8{lanes_reg[2]}},
        {8{lanes_reg[1]}}, {8{lanes_reg[0]}}};
    assign sync_mode_out = sync_mode_reg;
endmodule

// >>> hbp_host.sv
// Purpose: Host bus master end driving the device pins
// Assumes: Strap chosen by mode input, held stable
// Notes:   Local clock made by divider in sync mode
`timescale 1ns/1ns
`include "hbp_consts.svh"
module hbp_host (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pins
    hbp_bus_if.host bus,
    // Mode
    input wire logic sync_mode_in,
    // Command
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_write_in,
    input wire logic [15:1] cmd_addr_in,
    input wire logic [3:0] cmd_be_n_in,
    input wire logic [31:0] cmd_wdata_in,
    // Answer
    output logic rsp_valid_out,
    output logic [31:0] rsp_rdata_out
);
    import hbp_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [32:0] meta_reg;
    logic [32:0] pin_reg;
    always_ff @(posedge clk_in) begin
        meta_reg <= {bus.async_ready, bus.bus_data};
        pin_reg <= meta_reg;
    end

    // ----------------------------------------
    // Local clock divider
    // ----------------------------------------
    logic [2:0] div_reg, div_next;
    logic local_bus_clock_reg, local_bus_clock_next;
    always_comb begin
        div_next = div_reg + 3'h1;
        local_bus_clock_next = local_bus_clock_reg;
        if (div_reg == 3'(`HBP_LOCAL_BUS_CLOCK_HALF - 1)) begin
            div_next = 3'h0;
            local_bus_clock_next = sync_mode_in ? !local_bus_clock_reg : 1'b1;
        end
    end

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    hbp_host_state_type state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [4:0] settle;
    // Sync mode also waits out a whole local clock, or stale ready is taken
    assign settle = sync_mode_in ? 5'(`HBP_HOST_SETTLE + 2 * `HBP_LOCAL_BUS_CLOCK_HALF)
        : 5'(`HBP_HOST_SETTLE);
    logic wr_reg, wr_next;
    logic [15:1] addr_reg, addr_next;
    logic [3:0] be_reg, be_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [31:0] rdata_reg, rdata_next;
    logic strobe_reg, strobe_next;
    logic rsp_reg, rsp_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        addr_next = addr_reg;
        be_next = be_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        strobe_next = strobe_reg;
        rsp_next = 1'b0;
        unique case (state_reg)
            HBP_H_IDLE: begin
                if (cmd_valid_in) begin
                    wr_next = cmd_write_in;
                    addr_next = cmd_addr_in;
                    // Upper enables stay idle in ISA mode
                    be_next = sync_mode_in ? cmd_be_n_in : {2'h3, cmd_be_n_in[1:0]};
                    wdata_next = cmd_wdata_in;
                    state_next = HBP_H_SETUP;
                end
            end
            HBP_H_SETUP: begin
                strobe_next = 1'b1;
                cnt_next = 5'h00;
                state_next = HBP_H_STROBE;
            end
            HBP_H_STROBE: begin
                // Old ready is stale until the device has seen the strobe
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == settle) begin
                    state_next = HBP_H_WAIT;
                end
            end
            HBP_H_WAIT: begin
                if (pin_reg[32]) begin
                    rdata_next = pin_reg[31:0];
                    strobe_next = 1'b0;
                    cnt_next = 5'h00;
                    state_next = HBP_H_RELEASE;
                end
            end
            HBP_H_RELEASE: begin
                // Hold address and data past the trailing edge
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == 5'(`HBP_HOST_SETTLE)) begin
                    rsp_next = 1'b1;
                    state_next = HBP_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_reg <= 3'h0;
            local_bus_clock_reg <= 1'b1;
            state_reg <= HBP_H_IDLE;
            cnt_reg <= 5'h00;
            wr_reg <= 1'b0;
            addr_reg <= 15'h0000;
            be_reg <= `HBP_BE_IDLE;
            wdata_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            strobe_reg <= 1'b0;
            rsp_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            local_bus_clock_reg <= local_bus_clock_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            be_reg <= be_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            strobe_reg <= strobe_next;
            rsp_reg <= rsp_next;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic active;
    assign active = (state_reg != HBP_H_IDLE);
    assign bus.addr = sync_mode_in ? {addr_reg[15:2], 1'b0} : addr_reg;
    assign bus.byte_enable_lane0_n = active ? be_reg[0] : 1'b1;
    assign bus.byte_enable_lane1_n = active ? be_reg[1] : 1'b1;
    assign bus.byte_enable_lane2_n = active ? be_reg[2] : 1'b1;
    assign bus.byte_enable_lane3_n = active ? be_reg[3] : 1'b1;
    assign bus.io_space_qualifier = !active;
    assign bus.read_strobe_n = sync_mode_in || !(strobe_reg && !wr_reg);
    assign bus.write_strobe_n = sync_mode_in || !(strobe_reg && wr_reg);
    assign bus.sync_address_strobe_n = sync_mode_in ? !strobe_reg : 1'b0;
    assign bus.sync_cycle_strobe_n = sync_mode_in ? !strobe_reg : 1'b1;
    assign bus.access_direction = sync_mode_in ? wr_reg : 1'b1;
    assign bus.ready_return_n = 1'b1;
    assign bus.local_bus_clock = local_bus_clock_reg;
    assign bus.bus_type_strap_n = !sync_mode_in;
    assign bus.host_data = wdata_reg;
    assign bus.host_data_oe_n = (active && wr_reg) ? be_reg : `HBP_BE_IDLE;
    assign cmd_ready_out = !active;
    assign rsp_valid_out = rsp_reg;
    assign rsp_rdata_out = rdata_reg;
endmodule

// >>> hbp_checker.sv
// Purpose: Pin-level checks between host and device ends
// Assumes: One clock domain, reset synchronous active low
// Notes:   Decode base handed in as a parameter
`timescale 1ns/1ns
module hbp_checker #(
    parameter logic [15:4] BASE = 12'h300
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Host driven pins
    input wire logic [15:1] addr,
    input wire logic byte_enable_lane0_n,
    input wire logic byte_enable_lane1_n,
    input wire logic byte_enable_lane2_n,
    input wire logic byte_enable_lane3_n,
    input wire logic io_space_qualifier,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic sync_address_strobe_n,
    input wire logic sync_cycle_strobe_n,
    input wire logic access_direction,
    input wire logic ready_return_n,
    input wire logic local_bus_clock,
    input wire logic bus_type_strap_n,
    // Device driven pins
    input wire logic [3:0] dev_data_oe_n,
    input wire logic async_ready,
    input wire logic local_device_select_n
);
    wire logic [3:0] be_vec = {byte_enable_lane3_n, byte_enable_lane2_n,
        byte_enable_lane1_n, byte_enable_lane0_n};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_rd_hit;
        $fell(read_strobe_n) ##0 (addr[15:4] == BASE && !io_space_qualifier);
    endsequence
    sequence s_ready_drop;
        ##[1:6] !async_ready;
    endsequence
    property p_hit;
        (!io_space_qualifier && addr[15:4] == BASE) [*4] |=> !local_device_select_n;
    endproperty
    property p_miss;
        (io_space_qualifier || addr[15:4] != BASE) [*4] |=> local_device_select_n;
    endproperty
    property p_ready;
        s_rd_hit |-> s_ready_drop;
    endproperty
    property p_setup;
        ($fell(read_strobe_n) || $fell(write_strobe_n))
            |-> $stable(addr) && !$past(io_space_qualifier);
    endproperty
    property p_isa_tie;
        bus_type_strap_n && !read_strobe_n |-> !sync_address_strobe_n && byte_enable_lane2_n
            && byte_enable_lane3_n && sync_cycle_strobe_n && access_direction
            && ready_return_n && local_bus_clock;
    endproperty
    property p_sync_tie;
        !bus_type_strap_n |-> read_strobe_n && write_strobe_n;
    endproperty
    property p_isa_upper;
        bus_type_strap_n |-> &dev_data_oe_n[3:2];
    endproperty
    property p_lane_oe;
        !read_strobe_n || !sync_cycle_strobe_n |-> (~dev_data_oe_n & be_vec) == 4'h0;
    endproperty
    property p_wr_nodrive;
        !write_strobe_n || (!sync_cycle_strobe_n && access_direction && !bus_type_strap_n)
            |-> &dev_data_oe_n;
    endproperty
    property p_dir;
        !bus_type_strap_n && !sync_cycle_strobe_n && !$past(sync_cycle_strobe_n)
            |-> $stable(access_direction);
    endproperty
    a_hit: assert property (p_hit) else $error("select not asserted on hit");
    a_miss: assert property (p_miss) else $error("select asserted on miss");
    a_ready: assert property (p_ready) else $error("ready did not drop");
    a_setup: assert property (p_setup) else $error("address not set up");
    a_isa_tie: assert property (p_isa_tie) else $error("unused pins not tied");
    a_sync_tie: assert property (p_sync_tie) else $error("strobe in sync mode");
    a_isa_upper: assert property (p_isa_upper) else $error("upper lane driven");
    a_lane_oe: assert property (p_lane_oe) else $error("unselected lane driven");
    a_wr_nodrive: assert property (p_wr_nodrive) else $error("drive during write");
    a_dir: assert property (p_dir) else $error("direction changed in cycle");
endmodule

// >>> hbp_bench.sv
// Purpose: Self-checking bench joining host and device ends
// Assumes: Bench answers device requests after a random delay
// Notes:   Mode change needs a reset, strap sampled at release
`timescale 1ns/1ns
module hbp_bench;
    import hbp_pkg::*;
    localparam logic [15:4] BASE = 12'h300;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sync_mode = 1'b1;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rsp_valid_out;
    logic [15:1] cmd_addr = 15'h0000;
    logic [3:0] cmd_be_n = 4'hF;
    logic [31:0] cmd_wdata = 32'h0000_0000, rsp_rdata_out, last_rdata = 32'h0000_0000;
    logic req_valid_out, req_write_out, sync_mode_out;
    logic [15:1] req_addr_out;
    logic [3:0] req_lanes_out;
    logic [31:0] req_wdata_out;
    logic rsp_valid_in = 1'b0;
    logic [31:0] rsp_rdata_in = 32'h0000_0000;
    logic [51:0] exp_q[$];
    logic [3:0] codes[7] = '{4'h0, 4'hE, 4'hD, 4'hC, 4'h3, 4'hB, 4'h7};
    integer seed = 32'ha28832be, errors = 0, checked = 0, cycles = 0;
    hbp_bus_if bus ();
    hbp_host hbp_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus),
        .sync_mode_in(sync_mode), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
        .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_be_n_in(cmd_be_n),
        .cmd_wdata_in(cmd_wdata), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out));
    hbp_device hbp_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus),
        .base_addr_in(BASE), .req_valid_out(req_valid_out), .req_write_out(req_write_out),
        .req_addr_out(req_addr_out), .req_lanes_out(req_lanes_out),
        .req_wdata_out(req_wdata_out), .rsp_valid_in(rsp_valid_in),
        .rsp_rdata_in(rsp_rdata_in), .sync_mode_out(sync_mode_out));
    hbp_checker #(.BASE(BASE)) hbp_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .addr(bus.addr), .byte_enable_lane0_n(bus.byte_enable_lane0_n),
        .byte_enable_lane1_n(bus.byte_enable_lane1_n),
        .byte_enable_lane2_n(bus.byte_enable_lane2_n),
        .byte_enable_lane3_n(bus.byte_enable_lane3_n),
        .io_space_qualifier(bus.io_space_qualifier), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .sync_address_strobe_n(bus.sync_address_strobe_n),
        .sync_cycle_strobe_n(bus.sync_cycle_strobe_n), .access_direction(bus.access_direction),
        .ready_return_n(bus.ready_return_n), .local_bus_clock(bus.local_bus_clock),
        .bus_type_strap_n(bus.bus_type_strap_n), .dev_data_oe_n(bus.dev_data_oe_n),
        .async_ready(bus.async_ready), .local_device_select_n(bus.local_device_select_n));
    always #5 clk_in = ~clk_in;
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task check(input logic [51:0] seen, input logic [51:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task results();
        $display("Counts: %0d compared, %0d mismatched", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [31:0] lane_mask(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction
    // Hang guard, far above the fewer than a thousand cycles needed
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    // ----------------------------------------
    // Device side responder and model
    // ----------------------------------------
    initial begin
        forever begin
            @(posedge clk_in);
            #1;
            if (req_valid_out === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check(1, 0);
                end else begin
                    check({req_write_out, req_addr_out, req_lanes_out, req_write_out ?
                        req_wdata_out : 32'h0000_0000}, exp_q.pop_front());
                end
                repeat ({$random(seed)} % 4) @(posedge clk_in);
                @(posedge clk_in);
                last_rdata = $random(seed);
                rsp_valid_in <= 1'b1;
                rsp_rdata_in <= last_rdata;
                @(posedge clk_in);
                rsp_valid_in <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Host side commands
    // ----------------------------------------
    task do_cmd(input logic wr, input logic [15:1] a, input logic [3:0] be, input logic hit);
        logic [3:0] lanes;
        logic [31:0] m, d;
        integer n;
        lanes = sync_mode ? ~be : (~be & 4'h3);
        m = lane_mask(lanes);
        d = $random(seed);
        if (hit) begin
            exp_q.push_back({wr, sync_mode ? {a[15:2], be[1:0] == 2'b11} : a, lanes,
                wr ? d & m : 32'h0000_0000});
        end
        @(posedge clk_in);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_be_n <= be;
        cmd_wdata <= d;
        @(posedge clk_in);
        cmd_valid <= 1'b0;
        for (n = 0; n < 400 && rsp_valid_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check(rsp_valid_out, 1'b1);
        if (!wr) begin
            check(rsp_rdata_out, hit ? last_rdata & m : 32'h0000_0000);
        end
    endtask
    task run_mode(input logic mode);
        integer i, n;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        sync_mode <= mode;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        check(sync_mode_out, mode);
        n = mode ? 7 : 3;
        // Writes then reads back to back over all seven enable codes in sync mode, the first three in ISA mode
        for (i = 0; i < 2 * n; i++) begin
            do_cmd(i < n, {BASE, 3'($random(seed))}, codes[i % n], 1'b1);
        end
        if (!mode) begin
            do_cmd(1'b0, {BASE ^ 12'h001, 3'h2}, 4'h0, 1'b0);
        end
        check(exp_q.size(), 0);
        $display("Test in mode %0d done, %0d mismatches so far", mode, errors);
    endtask
    initial begin
        run_mode(1'b1);
        run_mode(1'b0);
        results();
    end
endmodule
